// File: ricg_pkg.sv
// Shared constants and helpers for the identification code link
// Summary of operation
// - Device holds family, serial, range, CRC code.
// - CRC uses x8+x5+x4+1 feedback shift register.
// - CRC register cleared before first bit.
// - Bits enter LSB first: family, serial, range.
// - Shifting stored CRC through leaves zero.
// - Every bus byte moves least significant first.
// - Master addresses first, then memory command.
// - High-speed addressing byte switches link fast.
// - Memory commands accepted only after addressing.
package ricg_pkg;
	localparam int FAMILY_W = 8;
	localparam int SERIAL_W = 36;
	localparam int RANGE_W = 12;
	localparam int CRC_W = 8;
	localparam int BASE_W = FAMILY_W + SERIAL_W + RANGE_W;
	localparam int ID_W = BASE_W + CRC_W;
	// Family value is arbitrary
	localparam logic [7:0] FAMILY_CODE = 8'h5a;
	localparam logic [7:0] CRC_RESET = 8'h00;
	localparam logic [5:0] CNT_ZERO = 6'h00;
	localparam logic [5:0] CNT_ONE = 6'h01;
	localparam logic [5:0] BYTE_LAST = 6'h07;
	localparam logic [5:0] CRC_LAST = 6'h37;
	localparam logic [5:0] ID_LAST = 6'h3f;
	localparam logic [1:0] PH_BIT = 2'h0;
	localparam logic [1:0] PH_CMP = 2'h1;
	localparam logic [1:0] PH_DIR = 2'h2;
	// Addressing command bytes
	localparam logic [7:0] CMD_READ = 8'h0f;
	localparam logic [7:0] CMD_MATCH = 8'h1e;
	localparam logic [7:0] CMD_SEARCH = 8'h2d;
	localparam logic [7:0] CMD_CSEARCH = 8'h3c;
	localparam logic [7:0] CMD_SKIP = 8'h4b;
	localparam logic [7:0] CMD_HSKIP = 8'h5a;
	localparam logic [7:0] CMD_HMATCH = 8'h69;
	// Bit slot spacing in clock cycles, minus one
	localparam logic [7:0] STD_DIV = 8'h0f;
	localparam logic [7:0] HS_DIV = 8'h03;
	localparam logic [7:0] DIV_ZERO = 8'h00;
	localparam logic [7:0] DIV_ONE = 8'h01;

	typedef enum logic [2:0] {
		OP_READ,
		OP_MATCH,
		OP_SKIP,
		OP_HSKIP,
		OP_HMATCH,
		OP_MEM
	} ricg_op_t;

	// One step of the reflected x8+x5+x4+1 generator
	function automatic logic [7:0] ricg_crc_step(input logic [7:0] c,
		input logic b);
		logic fb;
		fb = c[0] ^ b;
		ricg_crc_step = {fb, c[7:5], c[4] ^ fb, c[3] ^ fb, c[2:1]};
	endfunction
endpackage

// File: ricg_link_if.sv
// Bit-slot link between the bus master and the identified device
`timescale 1ns/1ps
interface ricg_link_if;
	logic bus_rst;
	logic wr_stb;
	logic wr_bit;
	logic rd_stb;
	logic rd_bit;
	logic rd_vld;
	logic hs;

	modport dev (
		input bus_rst,
		input wr_stb,
		input wr_bit,
		input rd_stb,
		output rd_bit,
		output rd_vld,
		output hs
	);

	modport host (
		output bus_rst,
		output wr_stb,
		output wr_bit,
		output rd_stb,
		input rd_bit,
		input rd_vld,
		input hs
	);
endinterface

// File: ricg_dev.sv
// Device end: identification code, CRC generator and addressing layer
`timescale 1ns/1ps
module ricg_dev
	import ricg_pkg::*;
#(
	parameter logic [SERIAL_W-1:0] SERIAL_NUM = 36'h000000001,
	parameter logic [RANGE_W-1:0] RANGE_CODE = 12'h001
)(
	input wire logic clk_i,
	input wire logic srst_i,
	ricg_link_if.dev link,
	input wire logic alarm_i,
	output logic id_ready_o,
	output logic id_good_o,
	output logic [7:0] id_crc_o,
	output logic addr_done_o,
	output logic hs_o,
	output logic [7:0] mem_cmd_o,
	output logic mem_cmd_vld_o
);
	typedef enum logic [3:0] {
		D_CALC,
		D_IDLE,
		D_ROMCMD,
		D_READ,
		D_MATCH,
		D_SRCH,
		D_MEMCMD,
		D_MEM,
		D_DROP
	} ricg_dstate_t;

	ricg_dstate_t st_r, st_nxt;
	logic [5:0] cnt_r, cnt_nxt;
	logic [1:0] ph_r, ph_nxt;
	logic [7:0] crc_r, crc_nxt;
	logic [7:0] code_r, code_nxt;
	logic [7:0] sh_r, sh_nxt;
	logic [7:0] mem_r, mem_nxt;
	logic good_r, good_nxt;
	logic hs_r, hs_nxt;
	logic addr_r, addr_nxt;
	logic mvld_r, mvld_nxt;
	logic rbit_r, rbit_nxt;
	logic rvld_r, rvld_nxt;
	logic [ID_W-1:0] id_w;
	logic [7:0] byte_w;
	logic [7:0] step_w;
	logic cur_bit;

	// Serial order is family first, LSB first
	assign id_w = {code_r, RANGE_CODE, SERIAL_NUM, FAMILY_CODE};
	assign cur_bit = id_w[cnt_r];
	assign byte_w = {link.wr_bit, sh_r[7:1]};
	assign step_w = ricg_crc_step(crc_r, cur_bit);

	always_comb
	begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		ph_nxt = ph_r;
		crc_nxt = crc_r;
		code_nxt = code_r;
		sh_nxt = sh_r;
		mem_nxt = mem_r;
		good_nxt = good_r;
		hs_nxt = hs_r;
		addr_nxt = addr_r;
		mvld_nxt = 1'b0;
		// An idle wire reads high when nobody answers
		rbit_nxt = 1'b1;
		rvld_nxt = link.rd_stb;
		if (link.bus_rst && st_r != D_CALC)
		begin
			st_nxt = D_ROMCMD;
			cnt_nxt = CNT_ZERO;
			ph_nxt = PH_BIT;
			addr_nxt = 1'b0;
		end
		else
		begin
			case (st_r)
				D_CALC:
				begin
					// The code is built at power-up, not taken from a table
					crc_nxt = step_w;
					cnt_nxt = cnt_r + CNT_ONE;
					if (cnt_r == CRC_LAST)
						code_nxt = step_w;
					if (cnt_r == ID_LAST)
					begin
						good_nxt = (step_w == CRC_RESET);
						st_nxt = D_IDLE;
					end
				end
				D_ROMCMD:
				begin
					if (link.wr_stb)
					begin
						sh_nxt = byte_w;
						cnt_nxt = cnt_r + CNT_ONE;
						if (cnt_r == BYTE_LAST)
						begin
							cnt_nxt = CNT_ZERO;
							case (byte_w)
								CMD_READ:
									st_nxt = D_READ;
								CMD_MATCH:
									st_nxt = D_MATCH;
								CMD_HMATCH:
								begin
									st_nxt = D_MATCH;
									hs_nxt = 1'b1;
								end
								CMD_SEARCH:
									st_nxt = D_SRCH;
								CMD_CSEARCH:
									st_nxt = alarm_i ? D_SRCH : D_DROP;
								CMD_SKIP:
								begin
									st_nxt = D_MEMCMD;
									addr_nxt = 1'b1;
								end
								CMD_HSKIP:
								begin
									st_nxt = D_MEMCMD;
									addr_nxt = 1'b1;
									hs_nxt = 1'b1;
								end
								default:
									st_nxt = D_DROP;
							endcase
						end
					end
				end
				D_READ:
				begin
					if (link.rd_stb)
					begin
						rbit_nxt = cur_bit;
						cnt_nxt = cnt_r + CNT_ONE;
						if (cnt_r == ID_LAST)
						begin
							st_nxt = D_MEMCMD;
							addr_nxt = 1'b1;
						end
					end
				end
				D_MATCH:
				begin
					if (link.wr_stb)
					begin
						cnt_nxt = cnt_r + CNT_ONE;
						if (link.wr_bit != cur_bit)
							st_nxt = D_DROP;
						else if (cnt_r == ID_LAST)
						begin
							st_nxt = D_MEMCMD;
							addr_nxt = 1'b1;
						end
					end
				end
				D_SRCH:
				begin
					case (ph_r)
						PH_BIT:
						begin
							if (link.rd_stb)
							begin
								rbit_nxt = cur_bit;
								ph_nxt = PH_CMP;
							end
						end
						PH_CMP:
						begin
							if (link.rd_stb)
							begin
								rbit_nxt = ~cur_bit;
								ph_nxt = PH_DIR;
							end
						end
						default:
						begin
							if (link.wr_stb)
							begin
								ph_nxt = PH_BIT;
								cnt_nxt = cnt_r + CNT_ONE;
								if (link.wr_bit != cur_bit)
									st_nxt = D_DROP;
								else if (cnt_r == ID_LAST)
								begin
									st_nxt = D_MEMCMD;
									addr_nxt = 1'b1;
								end
							end
						end
					endcase
				end
				D_MEMCMD:
				begin
					// Reached only with addressing finished
					if (link.wr_stb && addr_r)
					begin
						sh_nxt = byte_w;
						cnt_nxt = cnt_r + CNT_ONE;
						if (cnt_r == BYTE_LAST)
						begin
							mem_nxt = byte_w;
							mvld_nxt = 1'b1;
							st_nxt = D_MEM;
						end
					end
				end
				default:
				begin
					st_nxt = st_r;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			st_r <= D_CALC;
			cnt_r <= CNT_ZERO;
			ph_r <= PH_BIT;
			crc_r <= CRC_RESET;
			code_r <= CRC_RESET;
			sh_r <= CRC_RESET;
			mem_r <= CRC_RESET;
			good_r <= 1'b0;
			hs_r <= 1'b0;
			addr_r <= 1'b0;
			mvld_r <= 1'b0;
			rbit_r <= 1'b1;
			rvld_r <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			ph_r <= ph_nxt;
			crc_r <= crc_nxt;
			code_r <= code_nxt;
			sh_r <= sh_nxt;
			mem_r <= mem_nxt;
			good_r <= good_nxt;
			hs_r <= hs_nxt;
			addr_r <= addr_nxt;
			mvld_r <= mvld_nxt;
			rbit_r <= rbit_nxt;
			rvld_r <= rvld_nxt;
		end
	end

	assign link.rd_bit = rbit_r;
	assign link.rd_vld = rvld_r;
	assign link.hs = hs_r;
	assign hs_o = hs_r;
	assign id_ready_o = (st_r != D_CALC);
	assign id_good_o = good_r;
	assign id_crc_o = code_r;
	assign addr_done_o = addr_r;
	assign mem_cmd_o = mem_r;
	assign mem_cmd_vld_o = mvld_r;
endmodule

// File: ricg_host.sv
// Master end: addresses the device, reads and checks its code
`timescale 1ns/1ps
module ricg_host
	import ricg_pkg::*;
(
	input wire logic clk_i,
	input wire logic srst_i,
	ricg_link_if.host link,
	input wire logic op_vld_i,
	input wire ricg_op_t op_i,
	input wire logic [7:0] mem_byte_i,
	input wire logic [ID_W-1:0] match_id_i,
	output logic busy_o,
	output logic done_o,
	output logic refused_o,
	output logic addr_ok_o,
	output logic [ID_W-1:0] id_o,
	output logic crc_ok_o
);
	typedef enum logic [2:0] {
		H_IDLE,
		H_RST,
		H_CMD,
		H_RDID,
		H_MATCH,
		H_MEM
	} ricg_hstate_t;

	ricg_hstate_t st_r, st_nxt;
	ricg_op_t op_r, op_nxt;
	logic [5:0] cnt_r, cnt_nxt;
	logic [7:0] div_r, div_nxt;
	logic [ID_W-1:0] sh_r, sh_nxt;
	logic [ID_W-1:0] id_r, id_nxt;
	logic [7:0] crc_r, crc_nxt;
	logic ok_r, ok_nxt;
	logic addr_r, addr_nxt;
	logic done_r, done_nxt;
	logic ref_r, ref_nxt;
	logic brst_r, brst_nxt;
	logic wstb_r, wstb_nxt;
	logic wbit_r, wbit_nxt;
	logic rstb_r, rstb_nxt;
	logic tick;
	logic [7:0] cmd_w;
	logic [7:0] step_w;
	logic [ID_W-1:0] rx_w;

	// Slot rate follows the mode the device reports
	assign tick = (div_r == DIV_ZERO);
	assign step_w = ricg_crc_step(crc_r, link.rd_bit);
	assign rx_w = {link.rd_bit, sh_r[ID_W-1:1]};

	always_comb
	begin
		case (op_r)
			OP_READ: cmd_w = CMD_READ;
			OP_MATCH: cmd_w = CMD_MATCH;
			OP_SKIP: cmd_w = CMD_SKIP;
			OP_HSKIP: cmd_w = CMD_HSKIP;
			OP_HMATCH: cmd_w = CMD_HMATCH;
			default: cmd_w = CMD_SKIP;
		endcase
	end

	always_comb
	begin
		st_nxt = st_r;
		op_nxt = op_r;
		cnt_nxt = cnt_r;
		div_nxt = tick ? (link.hs ? HS_DIV : STD_DIV) : div_r - DIV_ONE;
		sh_nxt = sh_r;
		id_nxt = id_r;
		crc_nxt = crc_r;
		ok_nxt = ok_r;
		addr_nxt = addr_r;
		done_nxt = 1'b0;
		ref_nxt = 1'b0;
		brst_nxt = 1'b0;
		wstb_nxt = 1'b0;
		wbit_nxt = wbit_r;
		rstb_nxt = 1'b0;
		case (st_r)
			H_IDLE:
			begin
				if (op_vld_i)
				begin
					cnt_nxt = CNT_ZERO;
					op_nxt = op_i;
					if (op_i != OP_MEM)
						st_nxt = H_RST;
					else if (addr_r)
					begin
						sh_nxt = {{(ID_W-8){1'b0}}, mem_byte_i};
						st_nxt = H_MEM;
					end
					else
						ref_nxt = 1'b1;
				end
			end
			H_RST:
			begin
				if (tick)
				begin
					brst_nxt = 1'b1;
					addr_nxt = 1'b0;
					sh_nxt = {{(ID_W-8){1'b0}}, cmd_w};
					st_nxt = H_CMD;
				end
			end
			H_CMD, H_MATCH, H_MEM:
			begin
				if (tick)
				begin
					wstb_nxt = 1'b1;
					wbit_nxt = sh_r[0];
					sh_nxt = sh_r >> 1;
					cnt_nxt = cnt_r + CNT_ONE;
					if ((st_r != H_MATCH && cnt_r == BYTE_LAST) ||
						cnt_r == ID_LAST)
					begin
						cnt_nxt = CNT_ZERO;
						st_nxt = H_IDLE;
						done_nxt = 1'b1;
						if (st_r == H_MATCH)
							addr_nxt = 1'b1;
						else if (st_r == H_CMD)
						begin
							case (op_r)
								OP_READ:
								begin
									st_nxt = H_RDID;
									done_nxt = 1'b0;
									crc_nxt = CRC_RESET;
								end
								OP_MATCH, OP_HMATCH:
								begin
									st_nxt = H_MATCH;
									done_nxt = 1'b0;
									sh_nxt = match_id_i;
								end
								default:
									addr_nxt = 1'b1;
							endcase
						end
					end
				end
			end
			H_RDID:
			begin
				rstb_nxt = tick;
				if (link.rd_vld)
				begin
					sh_nxt = rx_w;
					crc_nxt = step_w;
					cnt_nxt = cnt_r + CNT_ONE;
					if (cnt_r == ID_LAST)
					begin
						id_nxt = rx_w;
						ok_nxt = (step_w == CRC_RESET);
						addr_nxt = 1'b1;
						done_nxt = 1'b1;
						st_nxt = H_IDLE;
					end
				end
			end
			default:
				st_nxt = H_IDLE;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			st_r <= H_IDLE;
			op_r <= OP_READ;
			cnt_r <= CNT_ZERO;
			div_r <= STD_DIV;
			sh_r <= '0;
			id_r <= '0;
			crc_r <= CRC_RESET;
			ok_r <= 1'b0;
			addr_r <= 1'b0;
			done_r <= 1'b0;
			ref_r <= 1'b0;
			brst_r <= 1'b0;
			wstb_r <= 1'b0;
			wbit_r <= 1'b1;
			rstb_r <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
			op_r <= op_nxt;
			cnt_r <= cnt_nxt;
			div_r <= div_nxt;
			sh_r <= sh_nxt;
			id_r <= id_nxt;
			crc_r <= crc_nxt;
			ok_r <= ok_nxt;
			addr_r <= addr_nxt;
			done_r <= done_nxt;
			ref_r <= ref_nxt;
			brst_r <= brst_nxt;
			wstb_r <= wstb_nxt;
			wbit_r <= wbit_nxt;
			rstb_r <= rstb_nxt;
		end
	end

	assign link.bus_rst = brst_r;
	assign link.wr_stb = wstb_r;
	assign link.wr_bit = wbit_r;
	assign link.rd_stb = rstb_r;
	assign busy_o = (st_r != H_IDLE);
	assign done_o = done_r;
	assign refused_o = ref_r;
	assign addr_ok_o = addr_r;
	assign id_o = id_r;
	assign crc_ok_o = ok_r;
endmodule

// File: ricg_chk.sv
// Protocol checker for the identification code link
`timescale 1ns/1ps
module ricg_chk (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic bus_rst,
	input wire logic wr_stb,
	input wire logic wr_bit,
	input wire logic rd_stb,
	input wire logic rd_bit,
	input wire logic rd_vld,
	input wire logic hs
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (srst_i);

	// A read slot is answered once, on the next cycle only
	sequence s_answer;
		rd_stb ##1 (rd_vld && !rd_stb) ##1 !rd_vld;
	endsequence

	property p_rd_ans;
		rd_stb |-> s_answer;
	endproperty
	a_rd_ans: assert property (p_rd_ans)
		else $error("read slot not answered in one cycle");

	property p_rd_cause;
		rd_vld |-> $past(rd_stb);
	endproperty
	a_rd_cause: assert property (p_rd_cause)
		else $error("read answer without a read slot");

	property p_wr_gap;
		wr_stb |=> !wr_stb && !rd_stb;
	endproperty
	a_wr_gap: assert property (p_wr_gap)
		else $error("slots closer than two cycles");

	property p_bit_held;
		$changed(wr_bit) |-> wr_stb;
	endproperty
	a_bit_held: assert property (p_bit_held)
		else $error("write bit moved outside a write slot");

	property p_rst_pulse;
		bus_rst |=> !bus_rst && !rd_stb;
	endproperty
	a_rst_pulse: assert property (p_rst_pulse)
		else $error("bus reset not a single pulse");

	// A command write slot must follow bus reset within 20 cycles, before any read slot
	property p_cmd_first;
		bus_rst |-> (!rd_stb throughout (##[1:20] wr_stb));
	endproperty
	a_cmd_first: assert property (p_cmd_first)
		else $error("no command write after bus reset");

	property p_hs_keep;
		hs |=> hs;
	endproperty
	a_hs_keep: assert property (p_hs_keep)
		else $error("high speed dropped without reset");

	property p_hs_cause;
		$rose(hs) |-> $past(wr_stb) || $past(wr_stb, 2);
	endproperty
	a_hs_cause: assert property (p_hs_cause)
		else $error("high speed entered without a command write");

	c_hs: cover property ($rose(hs));
endmodule

// File: tb.sv
// Self-checking bench joining master and device ends
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
	$display("BAD %s exp %h got %h", nm, (e), (g)); end end
module tb;
	import ricg_pkg::*;
	localparam logic [SERIAL_W-1:0] SER = 36'h9a5c3e172;
	localparam logic [RANGE_W-1:0] RNG = 12'h6d1;
	logic clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic alarm_i = 1'b0;
	logic op_vld_i = 1'b0;
	ricg_op_t op_i = OP_READ;
	logic [7:0] mem_byte_i = 8'h00;
	logic [ID_W-1:0] match_id_i = '0;
	logic id_ready_o, id_good_o, addr_done_o, hs_o, mem_cmd_vld_o;
	logic [7:0] id_crc_o, mem_cmd_o;
	logic busy_o, done_o, refused_o, addr_ok_o, crc_ok_o;
	logic [ID_W-1:0] id_o;
	int fails = 0;
	int n_checks = 0;
	int cyc = 0;
	int nvld = 0;
	logic [7:0] wr_sr = 8'h00;
	logic [ID_W-1:0] rd_sr = '0;
	logic [ID_W-1:0] exp_id;
	logic [7:0] exp_crc;
	ricg_op_t ops[7] = '{OP_READ, OP_SKIP, OP_MATCH, OP_MATCH, OP_HSKIP,
		OP_HMATCH, OP_READ};
	logic [7:0] cmds[7] = '{CMD_READ, CMD_SKIP, CMD_MATCH, CMD_MATCH,
		CMD_HSKIP, CMD_HMATCH, CMD_READ};

	ricg_link_if lk();
	ricg_dev #(.SERIAL_NUM(SER), .RANGE_CODE(RNG)) i_ricg_dev (
		.clk_i(clk_i), .srst_i(srst_i), .link(lk), .alarm_i(alarm_i),
		.id_ready_o(id_ready_o), .id_good_o(id_good_o),
		.id_crc_o(id_crc_o), .addr_done_o(addr_done_o), .hs_o(hs_o),
		.mem_cmd_o(mem_cmd_o), .mem_cmd_vld_o(mem_cmd_vld_o));
	ricg_host i_ricg_host (
		.clk_i(clk_i), .srst_i(srst_i), .link(lk), .op_vld_i(op_vld_i),
		.op_i(op_i), .mem_byte_i(mem_byte_i), .match_id_i(match_id_i),
		.busy_o(busy_o), .done_o(done_o), .refused_o(refused_o),
		.addr_ok_o(addr_ok_o), .id_o(id_o), .crc_ok_o(crc_ok_o));
	ricg_chk i_ricg_chk (
		.clk_i(clk_i), .srst_i(srst_i), .bus_rst(lk.bus_rst),
		.wr_stb(lk.wr_stb), .wr_bit(lk.wr_bit), .rd_stb(lk.rd_stb),
		.rd_bit(lk.rd_bit), .rd_vld(lk.rd_vld), .hs(lk.hs));

	always #5 clk_i = ~clk_i;

	// Wire monitor: bits are gathered LSB first as they pass
	always @(posedge clk_i)
	begin
		cyc <= cyc + 1;
		if (lk.wr_stb === 1'b1)
			wr_sr <= {lk.wr_bit, wr_sr[7:1]};
		if (lk.rd_vld === 1'b1)
			rd_sr <= {lk.rd_bit, rd_sr[ID_W-1:1]};
		if (mem_cmd_vld_o === 1'b1)
			nvld <= nvld + 1;
		if (cyc == 40000)
		begin
			fails++;
			report_and_stop();
		end
	end

	function automatic logic [7:0] crc_of(input logic [ID_W-1:0] v,
		input int n);
		int c;
		int fb;
		c = 0;
		for (int i = 0; i < n; i++)
		begin
			fb = (c ^ int'(v[i])) & 1;
			c = c >> 1;
			if (fb != 0)
				c = c ^ 32'h0000008c;
		end
		return 8'(c);
	endfunction

	task report_and_stop;
		$display("Checks %0d, mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task do_reset;
		int k;
		srst_i = 1'b1;
		repeat (4) @(posedge clk_i);
		#1 srst_i = 1'b0;
		k = 0;
		while (id_ready_o !== 1'b1 && k < 200)
		begin
			@(posedge clk_i);
			#1 k++;
		end
		`CHK("ready", 1'b1, id_ready_o)
	endtask

	task run_op(input ricg_op_t o, input logic [7:0] b,
		input logic [ID_W-1:0] m, output logic got_ref);
		int k;
		op_i = o;
		mem_byte_i = b;
		match_id_i = m;
		op_vld_i = 1'b1;
		@(posedge clk_i);
		#1 op_vld_i = 1'b0;
		if (o != OP_MEM)
			`CHK("busy", 1'b1, busy_o)
		k = 0;
		while (done_o !== 1'b1 && refused_o !== 1'b1 && k < 5000)
		begin
			@(posedge clk_i);
			#1 k++;
		end
		got_ref = (refused_o === 1'b1);
		if (k == 5000)
			fails++;
		@(posedge clk_i);
		#1;
		`CHK("idle", 1'b0, busy_o)
	endtask

	initial
	begin
		logic r, bad;
		logic [7:0] b, ew;
		logic [ID_W-1:0] mid;
		int v0;
		void'($urandom(36615));
		alarm_i = 1'($urandom);
		exp_crc = crc_of({8'h00, RNG, SER, FAMILY_CODE}, 56);
		exp_id = {exp_crc, RNG, SER, FAMILY_CODE};
		do_reset();
		`CHK("id_crc", exp_crc, id_crc_o)
		`CHK("id_good", 1'b1, id_good_o)
		run_op(OP_MEM, 8'ha5, '0, r);
		`CHK("refused", 1'b1, r)
		`CHK("mem_cnt", 0, nvld)
		for (int i = 0; i < 7; i++)
		begin
			bad = (i == 3);
			mid = exp_id;
			if (bad)
				mid[$urandom_range(63, 0)] ^= 1'b1;
			run_op(ops[i], 8'h00, mid, r);
			ew = cmds[i];
			if (ops[i] == OP_MATCH || ops[i] == OP_HMATCH)
				ew = mid[63:56];
			`CHK("wire_bits", ew, wr_sr)
			`CHK("addr_done", !bad, addr_done_o)
			`CHK("hs", (i >= 4), lk.hs)
			`CHK("hs_o", (i >= 4), hs_o)
			`CHK("addr_ok", 1'b1, addr_ok_o)
			if (ops[i] == OP_READ)
			begin
				`CHK("id", exp_id, id_o)
				`CHK("crc_ok", 1'b1, crc_ok_o)
				`CHK("rd_wire", exp_id, rd_sr)
			end
			b = 8'($urandom);
			v0 = nvld;
			run_op(OP_MEM, b, '0, r);
			// The command pulse is counted two edges after done rises
			@(posedge clk_i);
			#1;
			`CHK("mem_cnt", v0 + (bad ? 0 : 1), nvld)
			`CHK("mem_ref", 1'b0, r)
			`CHK("mem_wire", b, wr_sr)
			if (!bad)
				`CHK("mem_cmd", b, mem_cmd_o)
		end
		// A second reset must bring the link back to standard speed
		do_reset();
		`CHK("hs_clr", 1'b0, lk.hs)
		run_op(OP_MEM, 8'h3c, '0, r);
		`CHK("refused2", 1'b1, r)
		run_op(OP_READ, 8'h00, '0, r);
		`CHK("id_again", exp_id, id_o)
		`CHK("crc_ok2", 1'b1, crc_ok_o)
		report_and_stop();
	end
endmodule
